// File: verilog/sfpi_pkg.sv
// Constants and types shared by the serial flash pin interface
package sfpi_pkg;

	// Bits per serial byte
	localparam int unsigned BYTE_BITS = 8;

	// Default depth of the receive buffer
	localparam int unsigned RX_DEPTH  = 8;

	// Reset value of the bit counters
	localparam logic [2:0]  CNT_RST   = 3'h0;

	// Last bit index of a byte
	localparam logic [2:0]  CNT_LAST  = 3'h7;

	// Output lane modes of a transmit byte
	typedef enum logic [1:0] {
		SFPI_MODE_SINGLE = 2'h0,
		SFPI_MODE_DUAL   = 2'h1,
		SFPI_MODE_QUAD   = 2'h2
	} sfpi_mode_e;

endpackage : sfpi_pkg

// File: verilog/sfpi_top.sv
// Receive buffer and device-side pin logic of the serial flash port
`timescale 1ns/10ps
`default_nettype none

// ****************************************************************
// Receive buffer
// ****************************************************************
module sfpi_fifo #(
	parameter int unsigned W     = 8,
	parameter int unsigned DEPTH = 8
) (
	input  wire logic         clk_i,
	input  wire logic         rst_i,
	input  wire logic [W-1:0] in_data_i,
	input  wire logic         in_valid_i,
	output logic              in_ready_o,
	output logic [W-1:0]      out_data_o,
	output logic              out_valid_o,
	input  wire logic         out_ready_i
);
	import sfpi_pkg::*;

	localparam int unsigned AW = $clog2(DEPTH);

	logic [W-1:0] mem_ff [DEPTH];  // Storage, power-of-two depth
	logic [AW-1:0] wr_ff;          // Write pointer
	logic [AW-1:0] rd_ff;          // Read pointer
	logic [AW:0]   cnt_ff;         // Fill level
	logic [AW-1:0] nxt_wr;
	logic [AW-1:0] nxt_rd;
	logic [AW:0]   nxt_cnt;
	logic          push;
	logic          pop;

	// Pointer and level update
	always_comb begin
		push    = in_valid_i && in_ready_o;
		pop     = out_valid_o && out_ready_i;
		nxt_wr  = push ? wr_ff + 1'b1 : wr_ff;
		nxt_rd  = pop ? rd_ff + 1'b1 : rd_ff;
		nxt_cnt = cnt_ff;
		if (push && !pop) begin
			nxt_cnt = cnt_ff + 1'b1;
		end else if (pop && !push) begin
			nxt_cnt = cnt_ff - 1'b1;
		end
	end

	// Registers
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			wr_ff  <= '0;
			rd_ff  <= '0;
			cnt_ff <= '0;
		end else begin
			wr_ff  <= nxt_wr;
			rd_ff  <= nxt_rd;
			cnt_ff <= nxt_cnt;
		end
	end

	// Storage is written only, no reset needed
	always_ff @(posedge clk_i) begin
		if (push) begin
			mem_ff[wr_ff] <= in_data_i;
		end
	end

	// Honest full and empty from the level
	assign in_ready_o  = (cnt_ff != DEPTH[AW:0]);
	assign out_valid_o = (cnt_ff != '0);
	assign out_data_o  = mem_ff[rd_ff];

endmodule : sfpi_fifo

// ****************************************************************
// Pin interface top
// ****************************************************************
module sfpi_top #(
	parameter int unsigned RX_WORDS = sfpi_pkg::RX_DEPTH
) (
	input  wire logic             clk_i,
	input  wire logic             rst_i,
	input  wire logic             sck_i,
	input  wire logic             cs_n_i,
	input  wire logic             io0_i,
	output logic                  io0_o,
	output logic                  io0_oe_n_o,
	output logic                  io1_o,
	output logic                  io1_oe_n_o,
	input  wire logic             io2_i,
	output logic                  io2_o,
	output logic                  io2_oe_n_o,
	input  wire logic             io3_i,
	output logic                  io3_o,
	output logic                  io3_oe_n_o,
	input  wire logic             quad_io_enable_i,
	input  wire logic             status_protect_high_i,
	input  wire logic             status_protect_low_i,
	input  wire logic             status_write_req_i,
	output logic                  status_write_ok_o,
	input  wire logic             internal_busy_i,
	output logic                  standby_o,
	output logic                  paused_o,
	output logic [7:0]            rx_data_o,
	output logic                  rx_valid_o,
	input  wire logic             rx_ready_i,
	input  wire logic [7:0]       tx_data_i,
	input  wire sfpi_pkg::sfpi_mode_e tx_mode_i,
	input  wire logic             tx_valid_i,
	output logic                  tx_ready_o
);
	import sfpi_pkg::*;

	// ************************************************************
	// Link domain, clocked by the serial clock
	// ************************************************************
	logic       link_rst;     // Frame end or system reset
	logic       oe_rst;       // Also floats lanes while paused
	logic       pause;        // Pause request seen at the pins
	logic [2:0] rx_cnt_ff;    // Bit position inside a byte
	logic [6:0] rx_sh_ff;     // Bits gathered so far
	logic [7:0] rx_byte_ff;   // Last whole byte, read across
	logic       rx_tgl_ff;    // Flips once per whole byte
	logic [2:0] nxt_rx_cnt;
	logic [6:0] nxt_rx_sh;
	logic [7:0] nxt_rx_byte;
	logic       nxt_rx_tgl;

	// Deselect restarts the frame, so stray levels never count
	assign link_rst = rst_i || cs_n_i;
	// Pause only when the fourth pin is not a data lane
	// Level follows the pin, so entry and exit track its edges
	assign pause    = !quad_io_enable_i && !io3_i;
	assign oe_rst   = link_rst || pause;

	// Receive shifter; a paused edge leaves the position intact
	always_comb begin
		nxt_rx_cnt  = rx_cnt_ff;
		nxt_rx_sh   = rx_sh_ff;
		nxt_rx_byte = rx_byte_ff;
		nxt_rx_tgl  = rx_tgl_ff;
		if (!pause) begin
			nxt_rx_cnt = rx_cnt_ff + 3'h1;
			nxt_rx_sh  = {rx_sh_ff[5:0], io0_i};
			if (rx_cnt_ff == CNT_LAST) begin
				nxt_rx_byte = {rx_sh_ff, io0_i};
				nxt_rx_tgl  = !rx_tgl_ff;
			end
		end
	end

	// Position state clears with the frame
	always_ff @(posedge sck_i or posedge link_rst) begin
		if (link_rst) begin
			rx_cnt_ff <= CNT_RST;
			rx_sh_ff  <= '0;
		end else begin
			rx_cnt_ff <= nxt_rx_cnt;
			rx_sh_ff  <= nxt_rx_sh;
		end
	end

	// Toggle survives deselect, otherwise it would fake a byte
	always_ff @(posedge sck_i or posedge rst_i) begin
		if (rst_i) begin
			rx_byte_ff <= '0;
			rx_tgl_ff  <= 1'b0;
		end else begin
			rx_byte_ff <= nxt_rx_byte;
			rx_tgl_ff  <= nxt_rx_tgl;
		end
	end

	logic [7:0] tx_hold_ff;   // Byte offered by the core side
	sfpi_mode_e tx_hmode_ff;  // Its lane mode
	logic       tx_req_ff;    // Core-side offer toggle
	logic       treq_s1_ff;   // Offer toggle, first stage
	logic       treq_s2_ff;   // Offer toggle, second stage
	logic       tx_ack_ff;    // Taken toggle
	logic [7:0] tx_sh_ff;     // Bits still to launch
	sfpi_mode_e tx_mode_ff;   // Lane mode of the current byte
	logic [3:0] tx_left_ff;   // Bits left in the shifter
	logic [3:0] lane_ff;      // Launched lane levels
	logic [3:0] oe_n_ff;      // Lane enables, low drives
	logic [7:0] nxt_tx_sh;
	sfpi_mode_e nxt_tx_mode;
	logic [3:0] nxt_tx_left;
	logic       nxt_tx_ack;
	logic [3:0] nxt_lane;
	logic [3:0] nxt_drv;
	logic [3:0] nxt_oe_n;
	logic [7:0] cur;
	sfpi_mode_e cmode;
	logic [3:0] cleft;

	// Launch side: load an offered byte when empty, then shift per mode
	always_comb begin
		cur         = tx_sh_ff;
		cmode       = tx_mode_ff;
		cleft       = tx_left_ff;
		nxt_tx_ack  = tx_ack_ff;
		// Only take a byte while selected, else it would be lost
		if (tx_left_ff == 4'h0 && treq_s2_ff != tx_ack_ff
			&& !cs_n_i) begin
			// Core holds the byte still until the ack returns
			cur        = tx_hold_ff;
			cmode      = tx_hmode_ff;
			cleft      = 4'h8;
			nxt_tx_ack = !tx_ack_ff;
		end
		nxt_tx_sh   = cur;
		nxt_tx_mode = cmode;
		nxt_tx_left = cleft;
		nxt_lane    = lane_ff;
		nxt_drv     = 4'h0;
		if (pause) begin
			// Nothing moves while paused
			nxt_tx_sh   = tx_sh_ff;
			nxt_tx_mode = tx_mode_ff;
			nxt_tx_left = tx_left_ff;
			nxt_tx_ack  = tx_ack_ff;
			nxt_drv     = ~oe_n_ff;
		end else if (cleft != 4'h0) begin
			unique case (cmode)
				SFPI_MODE_SINGLE: begin
					nxt_lane    = {2'h0, cur[7], 1'b0};
					nxt_drv     = 4'h2;
					nxt_tx_sh   = {cur[6:0], 1'b0};
					nxt_tx_left = cleft - 4'h1;
				end
				SFPI_MODE_DUAL: begin
					// Output and input lines share each edge
					nxt_lane    = {2'h0, cur[7:6]};
					nxt_drv     = 4'h3;
					nxt_tx_sh   = {cur[5:0], 2'h0};
					nxt_tx_left = cleft - 4'h2;
				end
				SFPI_MODE_QUAD: begin
					// Upper lanes are data only with quad enabled
					nxt_lane    = cur[7:4];
					nxt_drv     = quad_io_enable_i ? 4'hF : 4'h3;
					nxt_tx_sh   = {cur[3:0], 4'h0};
					nxt_tx_left = cleft - 4'h4;
				end
				default: begin
					nxt_tx_left = 4'h0;
				end
			endcase
		end
		// Enables leave as active-low flops, no gate behind them
		nxt_oe_n    = ~nxt_drv;
	end

	// Falling-edge launch registers
	always_ff @(negedge sck_i or posedge link_rst) begin
		if (link_rst) begin
			tx_sh_ff   <= '0;
			tx_mode_ff <= SFPI_MODE_SINGLE;
			tx_left_ff <= 4'h0;
			lane_ff    <= 4'h0;
		end else begin
			tx_sh_ff   <= nxt_tx_sh;
			tx_mode_ff <= nxt_tx_mode;
			tx_left_ff <= nxt_tx_left;
			lane_ff    <= nxt_lane;
		end
	end

	// Offer toggle crossing and ack; kept over deselect
	always_ff @(negedge sck_i or posedge rst_i) begin
		if (rst_i) begin
			treq_s1_ff <= 1'b0;
			treq_s2_ff <= 1'b0;
			tx_ack_ff  <= 1'b0;
		end else begin
			treq_s1_ff <= tx_req_ff;
			treq_s2_ff <= treq_s1_ff;
			tx_ack_ff  <= nxt_tx_ack;
		end
	end

	// Drive flags float at once on deselect or pause
	always_ff @(negedge sck_i or posedge oe_rst) begin
		if (oe_rst) begin
			oe_n_ff <= 4'hF;
		end else begin
			oe_n_ff <= nxt_oe_n;
		end
	end

	// Pins straight from flops; enables are active low
	assign io0_o      = lane_ff[0];
	assign io1_o      = lane_ff[1];
	assign io2_o      = lane_ff[2];
	assign io3_o      = lane_ff[3];
	assign io0_oe_n_o = oe_n_ff[0];
	assign io1_oe_n_o = oe_n_ff[1];
	assign io2_oe_n_o = oe_n_ff[2];
	assign io3_oe_n_o = oe_n_ff[3];

	// ************************************************************
	// Core domain
	// ************************************************************
	logic [1:0] cs_sy_ff;     // Chip select synchroniser
	logic [1:0] wp_sy_ff;     // Protect pin synchroniser
	logic [1:0] hd_sy_ff;     // Pause pin synchroniser
	logic [1:0] rt_sy_ff;     // Byte toggle synchroniser
	logic [1:0] ak_sy_ff;     // Ack toggle synchroniser
	logic       rx_seen_ff;   // Last byte toggle taken in
	logic       ok_ff;        // Status write allowed
	logic       stby_ff;      // Standby flag
	logic       pau_ff;       // Paused flag
	logic       trdy_ff;      // Offer register free
	logic       nxt_seen;
	logic       nxt_ok;
	logic       nxt_stby;
	logic       nxt_pau;
	logic       nxt_trdy;
	logic       nxt_req;
	logic [7:0] nxt_hold;
	sfpi_mode_e nxt_hmode;
	logic       protect;
	logic       f_valid;
	logic       f_ready;
	logic       load;

	// Byte arrives while its toggle differs from the one taken
	assign f_valid = (rt_sy_ff[1] != rx_seen_ff);
	assign load    = tx_valid_i && trdy_ff;

	// Core-side next values
	always_comb begin
		// Only this configuration honours the protect pin
		protect  = !quad_io_enable_i && !status_protect_high_i
			&& status_protect_low_i;
		// Low protect pin refuses status changes
		nxt_ok   = status_write_req_i && !(protect && !wp_sy_ff[1]);
		// Busy internal work holds off standby after deselect
		nxt_stby = cs_sy_ff[1] && !internal_busy_i;
		nxt_pau  = !cs_sy_ff[1] && !quad_io_enable_i && !hd_sy_ff[1];
		// Stalls the crossing until the buffer has room
		nxt_seen = (f_valid && f_ready) ? rt_sy_ff[1] : rx_seen_ff;
		nxt_req  = load ? !tx_req_ff : tx_req_ff;
		nxt_hold = load ? tx_data_i : tx_hold_ff;
		nxt_hmode = load ? tx_mode_i : tx_hmode_ff;
		nxt_trdy = (ak_sy_ff[1] == nxt_req);
	end

	// Core-side registers
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			cs_sy_ff    <= 2'h3;
			wp_sy_ff    <= 2'h3;
			hd_sy_ff    <= 2'h3;
			rt_sy_ff    <= 2'h0;
			ak_sy_ff    <= 2'h0;
			rx_seen_ff  <= 1'b0;
			ok_ff       <= 1'b0;
			stby_ff     <= 1'b0;
			pau_ff      <= 1'b0;
			trdy_ff     <= 1'b0;
			tx_req_ff   <= 1'b0;
			tx_hold_ff  <= '0;
			tx_hmode_ff <= SFPI_MODE_SINGLE;
		end else begin
			cs_sy_ff    <= {cs_sy_ff[0], cs_n_i};
			wp_sy_ff    <= {wp_sy_ff[0], io2_i};
			hd_sy_ff    <= {hd_sy_ff[0], io3_i};
			rt_sy_ff    <= {rt_sy_ff[0], rx_tgl_ff};
			ak_sy_ff    <= {ak_sy_ff[0], tx_ack_ff};
			rx_seen_ff  <= nxt_seen;
			ok_ff       <= nxt_ok;
			stby_ff     <= nxt_stby;
			pau_ff      <= nxt_pau;
			trdy_ff     <= nxt_trdy;
			tx_req_ff   <= nxt_req;
			tx_hold_ff  <= nxt_hold;
			tx_hmode_ff <= nxt_hmode;
		end
	end

	assign status_write_ok_o = ok_ff;
	assign standby_o         = stby_ff;
	assign paused_o          = pau_ff;
	assign tx_ready_o        = trdy_ff;

	// Received bytes wait here for the core
	sfpi_fifo #(
		.W     (BYTE_BITS),
		.DEPTH (RX_WORDS)
	) u_rx_fifo (
		.clk_i       (clk_i),
		.rst_i       (rst_i),
		.in_data_i   (rx_byte_ff),
		.in_valid_i  (f_valid),
		.in_ready_o  (f_ready),
		.out_data_o  (rx_data_o),
		.out_valid_o (rx_valid_o),
		.out_ready_i (rx_ready_i)
	);

endmodule : sfpi_top

`default_nettype wire

// File: verif/sfpi_chk.sv
// Assertion checker for the serial flash pin interface
`timescale 1ns/10ps
`default_nettype none
// ****************************************************************
// Checker
// ****************************************************************
module sfpi_chk (
	input  wire logic clk_i,
	input  wire logic rst_i,
	input  wire logic cs_n_i,
	input  wire logic io2_i,
	input  wire logic io3_i,
	input  wire logic io0_oe_n_o,
	input  wire logic io1_oe_n_o,
	input  wire logic io2_oe_n_o,
	input  wire logic io3_oe_n_o,
	input  wire logic quad_io_enable_i,
	input  wire logic status_protect_high_i,
	input  wire logic status_protect_low_i,
	input  wire logic status_write_req_i,
	input  wire logic status_write_ok_o,
	input  wire logic internal_busy_i,
	input  wire logic standby_o,
	input  wire logic paused_o,
	input  wire logic rx_valid_o,
	input  wire logic rx_ready_i
);
	// Everything is judged on the core clock
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	logic cfg; // Protect pin honoured
	logic flt; // All four lanes released
	assign cfg = !quad_io_enable_i && !status_protect_high_i
		&& status_protect_low_i;
	assign flt = io0_oe_n_o & io1_oe_n_o & io2_oe_n_o & io3_oe_n_o;
	// Two samples high so the async float has surely landed
	a_desel_float: assert property (
		cs_n_i && $past(cs_n_i) |-> flt)
		else $error("lane driven while deselected");
	a_pause_float: assert property (
		!cs_n_i && !quad_io_enable_i && !io3_i && $past(!io3_i) |-> flt)
		else $error("lane driven while paused");
	a_quad_lanes: assert property (
		!quad_io_enable_i && $past(!quad_io_enable_i)
		|-> io2_oe_n_o && io3_oe_n_o)
		else $error("upper lanes driven without quad enable");
	// Window of four covers the two-stage sync and the register
	a_protect_block: assert property (
		(cfg && !io2_i)[*4] |=> !status_write_ok_o)
		else $error("status write allowed while protected");
	a_protect_pass: assert property (
		(cfg && io2_i)[*4] ##0 status_write_req_i |=> status_write_ok_o)
		else $error("status write refused with protect high");
	a_protect_off: assert property (
		status_write_req_i && !cfg |=> status_write_ok_o)
		else $error("status write refused outside protect setup");
	a_standby_busy: assert property (
		internal_busy_i |=> !standby_o)
		else $error("standby during internal operation");
	a_standby_idle: assert property (
		(cs_n_i && !internal_busy_i)[*4] |=> standby_o)
		else $error("no standby after deselect");
	a_pause_start: assert property (
		(!cs_n_i && !quad_io_enable_i && !io3_i)[*4] |=> paused_o)
		else $error("pause not entered");
	a_pause_end: assert property (
		(!cs_n_i && io3_i)[*4] |=> !paused_o)
		else $error("pause not left");
	a_no_pause_qe: assert property (
		quad_io_enable_i |=> !paused_o)
		else $error("pause taken in quad setup");
	// Main scenarios reached
	c_pause: cover property (paused_o);
	c_pop: cover property (rx_valid_o && rx_ready_i);
	c_block: cover property (status_write_req_i ##1 !status_write_ok_o);
endmodule : sfpi_chk
bind sfpi_top sfpi_chk chk_u (.*);
`default_nettype wire

// File: verif/sfpi_host.sv
// Host serial master model driving the flash pins
`timescale 1ns/10ps
`default_nettype none
// ****************************************************************
// Host model
// ****************************************************************
module sfpi_host (
	output logic            sck_o,
	output logic            cs_n_o,
	output logic            d0_o,
	output logic            d0_en_o,
	output logic            hold_n_o,
	input  wire logic [3:0] io_i,
	input  wire logic       drv_i
);
	// Clock stands low outside frames
	initial begin
		sck_o = 1'b0;
		cs_n_o = 1'b1;
		d0_o = 1'b0;
		d0_en_o = 1'b0;
		hold_n_o = 1'b1;
	end
	// One 12 ns period, returns 1 ns after the fall
	task automatic tick;
		#6 sck_o = 1'b1;
		#5 sck_o = 1'b0;
		#1;
	endtask : tick
	// Frame edges with the clock low
	task automatic sel(input logic on);
		#5 cs_n_o = !on;
		#5;
	endtask : sel
	// Shift bits hi..lo of a byte, MSB first
	task automatic wr_bits(input logic [7:0] b, input int hi, input int lo);
		d0_en_o = 1'b1;
		for (int i = hi; i >= lo; i--) begin
			d0_o = b[i];
			tick();
		end
	endtask : wr_bits
	// Pause pin edge, only ever with the clock low
	task automatic hold(input logic on);
		#3 hold_n_o = !on;
		#3;
	endtask : hold
	// Dummy clocks until lanes drive, then w bits a period
	task automatic rd(input int w, output logic [7:0] b);
		int n;
		d0_en_o = 1'b0;
		n = 0;
		while (!drv_i && n < 8) begin
			tick();
			n++;
		end
		for (int k = 0; k < 8 / w; k++) begin
			#4;
			b = (w == 1) ? {b[6:0], io_i[1]} :
				(w == 2) ? {b[5:0], io_i[1:0]} : {b[3:0], io_i};
			#1 sck_o = 1'b1;
			#6 sck_o = 1'b0;
			#1;
		end
	endtask : rd
endmodule : sfpi_host
`default_nettype wire

// File: verif/tb_top.sv
// Self-checking bench for the serial flash pin interface
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, e) begin \
	tests_run++; \
	if ((a) !== (e)) begin \
		fail_count++; \
		$display("MISMATCH t=%0t got=%h exp=%h", $time, a, e); \
	end \
end
// ****************************************************************
// Bench top
// ****************************************************************
module tb_top;
	import sfpi_pkg::*;
	logic clk_i, rst_i, qe, sph, spl, wreq, wok, busy, stby, psd;
	logic rxv, rxr, txv, txr, sck, cs_n, hd0, hen, hold_n, wp_n;
	logic i0, i1, i2, i3;
	logic [3:0] o, oe_n; // Lane data and enables
	logic [7:0] rxd, txd, got;
	sfpi_mode_e txm;
	int fail_count = 0;
	int tests_run = 0;
	// Wire levels from all drivers; released lines never keep a value
	assign i0 = !oe_n[0] ? o[0] : (hen ? hd0 : ~hd0);
	assign i1 = !oe_n[1] ? o[1] : ~o[1];
	assign i2 = !oe_n[2] ? o[2] : wp_n;
	assign i3 = !oe_n[3] ? o[3] : hold_n;
	sfpi_top #(.RX_WORDS(8)) dut_u (
		.clk_i(clk_i), .rst_i(rst_i), .sck_i(sck), .cs_n_i(cs_n),
		.io0_i(i0), .io0_o(o[0]), .io0_oe_n_o(oe_n[0]),
		.io1_o(o[1]), .io1_oe_n_o(oe_n[1]),
		.io2_i(i2), .io2_o(o[2]), .io2_oe_n_o(oe_n[2]),
		.io3_i(i3), .io3_o(o[3]), .io3_oe_n_o(oe_n[3]),
		.quad_io_enable_i(qe), .status_protect_high_i(sph),
		.status_protect_low_i(spl), .status_write_req_i(wreq),
		.status_write_ok_o(wok), .internal_busy_i(busy),
		.standby_o(stby), .paused_o(psd), .rx_data_o(rxd),
		.rx_valid_o(rxv), .rx_ready_i(rxr), .tx_data_i(txd),
		.tx_mode_i(txm), .tx_valid_i(txv), .tx_ready_o(txr));
	sfpi_host host_u (.sck_o(sck), .cs_n_o(cs_n), .d0_o(hd0),
		.d0_en_o(hen), .hold_n_o(hold_n), .io_i({i3, i2, i1, i0}),
		.drv_i(!oe_n[1]));
	// Core clock, 25 ns
	initial begin
		clk_i = 1'b0;
		forever #12.5 clk_i = ~clk_i;
	end
	task automatic cyc(input int n);
		repeat (n) @(negedge clk_i);
	endtask : cyc
	// Verdict and end of run
	task automatic test_done;
		$display("tests %0d mismatches %0d", tests_run, fail_count);
		if (fail_count == 0 && tests_run > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : test_done
	// Wait bounded for a byte, judge it, pop it
	task automatic pop(input logic [7:0] e);
		int n;
		n = 0;
		@(negedge clk_i);
		while (rxv !== 1'b1 && n < 50) begin
			@(negedge clk_i);
			n++;
		end
		`CHK(rxv, 1'b1)
		`CHK(rxd, e)
		rxr = 1'b1;
		@(negedge clk_i);
		rxr = 1'b0;
	endtask : pop
	// Clocking while deselected leaves no trace
	task automatic t_desel;
		host_u.wr_bits(8'h3C, 7, 0);
		cyc(10);
		`CHK(rxv, 1'b0)
		`CHK(oe_n, 4'hF)
		$display("test desel done");
	endtask : t_desel
	// Two whole bytes and a partial one
	task automatic t_rx;
		host_u.sel(1'b1);
		host_u.wr_bits(8'hA5, 7, 0);
		host_u.wr_bits(8'h5A, 7, 0);
		host_u.wr_bits(8'hF0, 7, 4);
		cyc(4);
		`CHK(stby, 1'b0)
		host_u.sel(1'b0);
		pop(8'hA5);
		pop(8'h5A);
		cyc(10);
		`CHK(rxv, 1'b0)
		$display("test rx done");
	endtask : t_rx
	// Pause mid-byte, clock wrong bits meanwhile, resume
	task automatic t_pause;
		host_u.sel(1'b1);
		host_u.wr_bits(8'hC3, 7, 4);
		host_u.hold(1'b1);
		cyc(6);
		`CHK(psd, 1'b1)
		`CHK(oe_n, 4'hF)
		host_u.wr_bits(8'h3C, 3, 2);
		host_u.hold(1'b0);
		cyc(6);
		`CHK(psd, 1'b0)
		host_u.wr_bits(8'hC3, 3, 0);
		host_u.sel(1'b0);
		pop(8'hC3);
		// Quad setup: the fourth pin low must not pause
		qe = 1'b1;
		host_u.sel(1'b1);
		host_u.hold(1'b1);
		cyc(6);
		`CHK(psd, 1'b0)
		host_u.hold(1'b0);
		host_u.sel(1'b0);
		cyc(2);
		qe = 1'b0;
		$display("test pause done");
	endtask : t_pause
	// Nine bytes against a stalled reader: eight stored, one held
	task automatic t_fifo;
		host_u.sel(1'b1);
		for (int i = 0; i < 9; i++)
			host_u.wr_bits({i[3:0], ~i[3:0]}, 7, 0);
		host_u.sel(1'b0);
		cyc(10);
		for (int i = 0; i < 9; i++)
			pop({i[3:0], ~i[3:0]});
		cyc(5);
		`CHK(rxv, 1'b0)
		$display("test fifo done");
	endtask : t_fifo
	// Every setup of the three bits, protect pin low then high
	task automatic t_prot;
		for (int c = 0; c < 8; c++) begin
			{qe, sph, spl} = c[2:0];
			wp_n = 1'b0;
			wreq = 1'b1;
			cyc(6);
			`CHK(wok, (c != 1))
			wp_n = 1'b1;
			cyc(6);
			`CHK(wok, 1'b1)
			wreq = 1'b0;
			cyc(2);
			`CHK(wok, 1'b0)
		end
		{qe, sph, spl} = 3'h0;
		$display("test protect done");
	endtask : t_prot
	// Standby waits for the internal operation
	task automatic t_stby;
		busy = 1'b1;
		cyc(5);
		`CHK(stby, 1'b0)
		busy = 1'b0;
		cyc(5);
		`CHK(stby, 1'b1)
		$display("test standby done");
	endtask : t_stby
	// Offer a byte, read it back at w bits a period
	task automatic tx(input logic [7:0] b, input sfpi_mode_e m, input int w);
		int n;
		n = 0;
		txd = b;
		txm = m;
		txv = 1'b1;
		while (txr !== 1'b1 && n < 20) begin
			@(negedge clk_i);
			n++;
		end
		@(negedge clk_i);
		txv = 1'b0;
		`CHK(txr, 1'b0)
		host_u.sel(1'b1);
		host_u.rd(w, got);
		host_u.sel(1'b0);
		`CHK(got, b)
		cyc(2);
		`CHK(oe_n, 4'hF)
	endtask : tx
	// Watchdog: all tests take some 300 core cycles
	initial begin
		#2000000;
		fail_count++;
		test_done();
	end
	initial begin
		rst_i = 1'b1;
		{qe, sph, spl, wreq, busy, rxr, txv} = 7'h00;
		txd = 8'h00;
		txm = SFPI_MODE_SINGLE;
		wp_n = 1'b1;
		cyc(4);
		rst_i = 1'b0;
		cyc(2);
		t_desel();
		t_rx();
		t_pause();
		t_fifo();
		t_prot();
		t_stby();
		tx(8'h96, SFPI_MODE_SINGLE, 1);
		tx(8'h69, SFPI_MODE_DUAL, 2);
		qe = 1'b1;
		tx(8'hB4, SFPI_MODE_QUAD, 4);
		$display("test tx done");
		test_done();
	end
endmodule : tb_top
`default_nettype wire
